/* logic/mcs_pkg.sv */
package mcs_pkg;
  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam int MCS_NREGS = 6;
  localparam logic [6:0] MCS_OFS_CAP_START = 7'h1D;
  localparam logic [6:0] MCS_OFS_TRIM_A = 7'h21;
  localparam logic [6:0] MCS_OFS_TRIM_B = 7'h22;
  localparam logic [6:0] MCS_OFS_CORE_RB = 7'h41;
  localparam logic [6:0] MCS_OFS_TRIM_C = 7'h43;
  localparam logic [6:0] MCS_OFS_SYNC_REF = 7'h48;

  // storage index of each register
  localparam logic [2:0] MCS_IDX_CAP_START = 3'h0;
  localparam logic [2:0] MCS_IDX_TRIM_A = 3'h1;
  localparam logic [2:0] MCS_IDX_TRIM_B = 3'h2;
  localparam logic [2:0] MCS_IDX_CORE_RB = 3'h3;
  localparam logic [2:0] MCS_IDX_TRIM_C = 3'h4;
  localparam logic [2:0] MCS_IDX_SYNC_REF = 3'h5;

  // reset values, by index
  localparam logic [15:0] MCS_RST [MCS_NREGS] = '{16'h05FF, 16'h7777, 16'h0007, 16'h65F0, 16'h50C8, 16'h0000};
  // writable bits, by index; read-only bits stay at their reset value
  localparam logic [15:0] MCS_WMASK [MCS_NREGS] = '{16'h1FFF, 16'hFFFF, 16'h3FFF, 16'hFE0F, 16'hFFFF, 16'h7FFF};

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int MCS_CAP_LSB = 0;
  localparam int MCS_CAP_MSB = 7;
  localparam int MCS_CORE_LSB = 4;
  localparam int MCS_CORE_MSB = 8;
  localparam int MCS_FORCE_BIT = 2;
  localparam int MCS_BYP_LSB = 0;
  localparam int MCS_BYP_MSB = 1;
  localparam logic [4:0] MCS_CORE_NONE = 5'h1F;
  localparam logic [15:0] MCS_READ_UNMAPPED = 16'h0000;

  // retime bypass codes
  localparam logic [1:0] MCS_BYP_NORMAL = 2'h0;
  localparam logic [1:0] MCS_BYP_ALL = 2'h1;
  localparam logic [1:0] MCS_BYP_ENGAGE = 2'h2;

  // frame reference path modes
  localparam logic [1:0] MCS_MODE_CONT = 2'h0;
  localparam logic [1:0] MCS_MODE_PULSER = 2'h1;
  localparam logic [1:0] MCS_MODE_REPEAT = 2'h2;

  // output function select code for multiplier operation
  localparam logic [2:0] MCS_FUNC_MULT = 3'h3;

  // calibration control carried to the multiplier
  typedef struct packed {
    logic mult_active;
    logic search_enable;
    logic [2:0] core_start;
    logic [7:0] cap_start;
  } mcs_cal_t;
endpackage

/* logic/mcs_regs.sv */
`timescale 1ns/100ps
// Notes on behaviour
// [RQ1] bits 7-0 hold calibration start capacitance, reset FFh, optional to write.
// [RQ2] software writes 0x5 into bits 12-8 of the start register.
// [RQ3] software writes 0x6666 to the register at 21h.
// [RQ4] software writes 0x5 to bits 13-0 at 22h.
// [RQ5] software writes 0x51CB to the register at 43h.
// [RQ6] software keeps 0x32 in bits 15-9 of the core readback register.
// [RQ7] read-only upper bits read zero; software writes zero to them.
// [RQ8] bits 8-4 read back active core, one bit low.
// [RQ9] force bit 2 acts as request input held high.
// [RQ10] while forced, external request input level is ignored.
// [RQ11] bypass 0: retime in generator modes, skip in repeater mode.
// [RQ12] bypass 1: skip retiming in every mode.
// [RQ13] bypass 2: retime in every mode; code 3 reserved.
// [RQ14] software may fully bypass in generator mode to save current.
// [RQ15] software retimes all modes only with phase-coherent request input.
// [RQ16] calibration in use only when output function select is 3.
// [RQ17] core force clear: start core; set: core used without search.
// [RQ18] registers 16 bits; read-only writes ignored; reads give reset or live.
module mcs_regs
  import mcs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port from the serial programming decoder
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // settings held elsewhere in the map
  input wire logic [2:0] output_function_select,
  input wire logic osc_core_force,
  input wire logic [2:0] osc_core_select,
  input wire logic [1:0] frame_ref_mode,
  // live inputs from pins and the oscillator
  input wire logic frame_ref_request_input,
  input wire logic [4:0] osc_core_live,
  // outputs to the frame reference path and multiplier
  output logic frame_ref_request_eff,
  output logic frame_ref_retime_engage,
  output mcs_cal_t cal_ctrl
);

  // ---------------------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------------------
  logic req_meta;
  logic req_sync;
  logic [4:0] core_meta;
  logic [4:0] core_sync;

  // two flops on asynchronous inputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      core_meta <= MCS_CORE_NONE;
      core_sync <= MCS_CORE_NONE;
    end else begin
      req_meta <= frame_ref_request_input;
      req_sync <= req_meta;
      core_meta <= osc_core_live;
      core_sync <= core_meta;
    end
  end

  // ---------------------------------------------------------------------------
  // core code filter
  // ---------------------------------------------------------------------------
  logic [4:0] core_prev;
  logic [4:0] core_held;
  logic [4:0] next_core_held;

  // the core code is a multi-bit word from another domain; a change of two bits
  // can be caught half done, so a code is taken only once two samples agree
  always_comb begin
    next_core_held = core_held;
    if (core_sync == core_prev) begin
      next_core_held = core_sync; // RQ8
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_prev <= MCS_CORE_NONE;
      core_held <= MCS_CORE_NONE;
    end else begin
      core_prev <= core_sync;
      core_held <= next_core_held;
    end
  end

  // ---------------------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------------------
  logic [15:0] regs [MCS_NREGS];
  logic [15:0] next_regs [MCS_NREGS];
  logic hit;
  logic [2:0] idx;

  // address decode
  always_comb begin
    hit = 1'b1;
    idx = MCS_IDX_CAP_START;
    if (reg_addr == MCS_OFS_CAP_START) begin
      idx = MCS_IDX_CAP_START;
    end else if (reg_addr == MCS_OFS_TRIM_A) begin
      idx = MCS_IDX_TRIM_A;
    end else if (reg_addr == MCS_OFS_TRIM_B) begin
      idx = MCS_IDX_TRIM_B;
    end else if (reg_addr == MCS_OFS_CORE_RB) begin
      idx = MCS_IDX_CORE_RB;
    end else if (reg_addr == MCS_OFS_TRIM_C) begin
      idx = MCS_IDX_TRIM_C;
    end else if (reg_addr == MCS_OFS_SYNC_REF) begin
      idx = MCS_IDX_SYNC_REF;
    end else begin
      hit = 1'b0;
    end
  end

  // per-register write with read-only bits masked off
  generate
    for (genvar i = 0; i < MCS_NREGS; i++) begin : g_reg
      always_comb begin
        next_regs[i] = regs[i];
        if (reg_wr && hit && idx == 3'(i)) begin
          next_regs[i] = (reg_wdata & MCS_WMASK[i]) | (regs[i] & ~MCS_WMASK[i]); // RQ18 RQ7
        end
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          regs[i] <= MCS_RST[i]; // RQ1
        end else begin
          regs[i] <= next_regs[i];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------------
  logic [15:0] next_rdata;
  logic next_rvalid;
  logic [4:0] core_view;

  // core readback: live core only while the multiplier is in use
  always_comb begin
    core_view = MCS_CORE_NONE;
    if (output_function_select == MCS_FUNC_MULT) begin
      core_view = core_held; // RQ8 RQ16
    end
    next_rvalid = reg_rd;
    next_rdata = MCS_READ_UNMAPPED;
    if (reg_rd && hit) begin
      next_rdata = regs[idx];
      if (idx == MCS_IDX_CORE_RB) begin
        next_rdata[MCS_CORE_MSB:MCS_CORE_LSB] = core_view; // RQ8 RQ18
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= MCS_READ_UNMAPPED;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      reg_rvalid <= next_rvalid;
    end
  end

  // ---------------------------------------------------------------------------
  // frame reference request and retiming
  // ---------------------------------------------------------------------------
  logic req_force;
  logic [1:0] byp;
  logic next_req_eff;
  logic next_engage;

  assign req_force = regs[MCS_IDX_SYNC_REF][MCS_FORCE_BIT];
  assign byp = regs[MCS_IDX_SYNC_REF][MCS_BYP_MSB:MCS_BYP_LSB];

  // force overrides the pin; bypass code picks the retiming path
  always_comb begin
    next_req_eff = req_sync;
    if (req_force) begin
      next_req_eff = 1'b1; // RQ9 RQ10
    end
    if (byp == MCS_BYP_ALL) begin
      next_engage = 1'b0; // RQ12
    end else if (byp == MCS_BYP_ENGAGE) begin
      next_engage = 1'b1; // RQ13
    end else begin
      next_engage = (frame_ref_mode != MCS_MODE_REPEAT); // RQ11
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_ref_request_eff <= 1'b0;
      frame_ref_retime_engage <= 1'b1;
    end else begin
      frame_ref_request_eff <= next_req_eff;
      frame_ref_retime_engage <= next_engage;
    end
  end

  // ---------------------------------------------------------------------------
  // multiplier calibration control
  // ---------------------------------------------------------------------------
  mcs_cal_t next_cal;

  // calibration start values, passed in every mode; active and search flags only in multiplier operation
  always_comb begin
    next_cal.mult_active = (output_function_select == MCS_FUNC_MULT); // RQ16
    next_cal.search_enable = next_cal.mult_active & ~osc_core_force; // RQ17
    next_cal.core_start = osc_core_select; // RQ17
    next_cal.cap_start = regs[MCS_IDX_CAP_START][MCS_CAP_MSB:MCS_CAP_LSB]; // RQ1
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_ctrl <= '0;
    end else begin
      cal_ctrl <= next_cal;
    end
  end

endmodule

/* dv/mcs_regs_sva.sv */
`timescale 1ns/100ps
module mcs_regs_sva
  import mcs_pkg::*;
(
  // register port
  input wire logic clk, rst_n, reg_wr, reg_rd, reg_rvalid,
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata, reg_rdata,
  // settings and live inputs
  input wire logic [2:0] output_function_select, osc_core_select,
  input wire logic [1:0] frame_ref_mode,
  input wire logic [4:0] osc_core_live,
  input wire logic osc_core_force, frame_ref_request_input,
  // derived outputs
  input wire logic frame_ref_request_eff, frame_ref_retime_engage,
  input wire mcs_cal_t cal_ctrl
);
  // ----
  // checks
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // write to the frame reference control, then a quiet cycle
  sequence ctl_wr(logic [15:0] m, logic [15:0] v);
    reg_wr && reg_addr == MCS_OFS_SYNC_REF && (reg_wdata & m) == v ##1 !reg_wr;
  endsequence
  rd_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read unanswered");
  rd_cause_a: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray answer");
  rd_idle_a: assert property (!reg_rvalid |-> reg_rdata == 16'h0000) else $error("idle data");
  hole_zero_a: assert property (reg_rd && reg_addr == 7'h00 |=> reg_rdata == 16'h0000) else $error("hole");
  force_high_a: assert property (ctl_wr(16'h0004, 16'h0004) |=> frame_ref_request_eff [*3])
    else $error("force not high");
  byp_skip_a: assert property (ctl_wr(16'h0003, 16'h0001) |=> !frame_ref_retime_engage)
    else $error("bypass ignored");
  byp_engage_a: assert property (ctl_wr(16'h0003, 16'h0002) |=> frame_ref_retime_engage)
    else $error("engage ignored");
  byp_normal_a: assert property (ctl_wr(16'h0003, 16'h0000) |=>
    frame_ref_retime_engage == ($past(frame_ref_mode) != MCS_MODE_REPEAT)) else $error("mode engage");
  mult_sel_a: assert property (rst_n |=>
    cal_ctrl.mult_active == ($past(output_function_select) == MCS_FUNC_MULT)) else $error("mult");
  search_a: assert property (rst_n |=> cal_ctrl.core_start == $past(osc_core_select) &&
    cal_ctrl.search_enable == ($past(output_function_select) == MCS_FUNC_MULT && !$past(osc_core_force)))
    else $error("search wrong");
endmodule

/* dv/tb.sv */
`timescale 1ns/100ps
module tb;
  import mcs_pkg::*;
  // ----
  // bench
  // ----
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid;
  logic osc_core_force = 1'b0, frame_ref_request_input = 1'b0;
  logic frame_ref_request_eff, frame_ref_retime_engage;
  logic [6:0] reg_addr = 7'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [2:0] output_function_select = 3'h1, osc_core_select = 3'h2;
  logic [1:0] frame_ref_mode = 2'h0;
  logic [4:0] osc_core_live = 5'h1F;
  mcs_cal_t cal_ctrl;
  int failures = 0, compares = 0, cycles = 0;
  logic [6:0] ofs [6] = '{7'h1D, 7'h21, 7'h22, 7'h41, 7'h43, 7'h48};
  logic [15:0] doc [6] = '{16'h0580, 16'h6666, 16'h0005, 16'h6400, 16'h51CB, 16'h0000};
  logic [4:0] cores [5] = '{5'h0F, 5'h17, 5'h1B, 5'h1D, 5'h1E};
  mcs_regs mcs_regs_inst (.*);
  // clock and hang guard
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (failures == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic hold(int n);
    repeat (n) @(negedge clk);
  endtask
  // one write strobe, then a quiet cycle
  task automatic wr(logic [6:0] a, logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // one read strobe, answer checked one cycle later
  task automatic rd(logic [6:0] a, logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    hold(1);
    cmp("rvalid", 16'h0001, {15'h0000, reg_rvalid});
    cmp("rdata", e, reg_rdata);
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(ofs[i], MCS_RST[i]);
    end
    rd(7'h00, 16'h0000);
    cmp("cap_start", 16'h00FF, {8'h00, cal_ctrl.cap_start});
    for (int i = 0; i < 6; i++) begin
      wr(ofs[i], 16'hFFFF);
      rd(ofs[i], (MCS_RST[i] & ~MCS_WMASK[i]) | MCS_WMASK[i]);
    end
    for (int i = 0; i < 6; i++) begin
      wr(ofs[i], doc[i]);
      rd(ofs[i], i == 3 ? 16'h65F0 : doc[i]);
    end
    cmp("cap_start", 16'h0080, {8'h00, cal_ctrl.cap_start});
    @(posedge clk);
    output_function_select <= MCS_FUNC_MULT;
    hold(2);
    cmp("cal", 16'h001A, {11'h000, cal_ctrl.mult_active, cal_ctrl.search_enable, cal_ctrl.core_start});
    @(posedge clk);
    osc_core_force <= 1'b1;
    hold(2);
    cmp("cal", 16'h0012, {11'h000, cal_ctrl.mult_active, cal_ctrl.search_enable, cal_ctrl.core_start});
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      osc_core_live <= cores[i];
      hold(4);
      rd(7'h41, {7'h32, cores[i], 4'h0});
    end
    wr(7'h48, 16'h0004);
    hold(3);
    cmp("req_eff", 16'h0001, {15'h0000, frame_ref_request_eff});
    wr(7'h48, 16'h0000);
    hold(4);
    cmp("req_eff", 16'h0000, {15'h0000, frame_ref_request_eff});
    @(posedge clk);
    frame_ref_request_input <= 1'b1;
    hold(4);
    cmp("req_eff", 16'h0001, {15'h0000, frame_ref_request_eff});
    for (int b = 0; b < 3; b++) begin
      for (int m = 0; m < 3; m++) begin
        @(posedge clk);
        frame_ref_mode <= m[1:0];
        wr(7'h48, {14'h0000, b[1:0]});
        hold(2);
        cmp("engage", {15'h0000, b == 2 || (b == 0 && m != 2)}, {15'h0000, frame_ref_retime_engage});
      end
    end
    complete_run();
  end
endmodule
bind mcs_regs mcs_regs_sva mcs_regs_sva_inst (.*);
